//--- verification/hpbp_host_model.sv
// host microcontroller model driving the parallel bus pins
`timescale 1ns/100ps
module hpbp_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] host_data_bus_out,
  input  wire logic       host_data_bus_oe_b,
  output logic      [7:0] host_data_bus_in,
  output logic      [3:0] reg_addr_in,
  output logic            rd_b,
  output logic            wr_b,
  output logic            cs_b,
  output logic            ale
);
  logic [7:0] drv;

  // wire level: device wins while it drives, else the host value
  assign host_data_bus_in = !host_data_bus_oe_b ? host_data_bus_out : drv;

  // strobe low and address pins tied while unused
  initial begin
    {ale, cs_b, wr_b, rd_b} = 4'h7;
    reg_addr_in = 4'h0;
    drv = 8'hA5;
  end

  // released bus toggles so a stale value is never mistaken for data
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #2 drv = ~drv;
    end
  endtask

  task automatic nm_acc(input logic rd, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge ref_clk);
    #2 reg_addr_in = a;
    drv = rd ? ~drv : d;
    {rd_b, wr_b, cs_b} = {rd, 2'b00};
    repeat (6) @(posedge ref_clk);
    // sampled once the edge has settled, released in the same step
    #2 q = host_data_bus_oe_b ? 8'hXX : host_data_bus_out;
    {rd_b, wr_b, cs_b} = 3'h7;
    reg_addr_in = 4'h0;
  endtask

  // address nibble held past the strobe fall
  task automatic mx_addr(input logic [3:0] a, input logic sel_b);
    @(posedge ref_clk);
    #2 drv = {4'h0, a};
    cs_b = sel_b;
    ale = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2 ale = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // multiplexed read or write, select dropped at the end
  task automatic mx_acc(input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #2 drv = rd ? ~drv : d;
    {rd_b, wr_b, cs_b} = {!rd, rd, 1'b0};
    repeat (6) @(posedge ref_clk);
    #2 q = host_data_bus_oe_b ? 8'hXX : host_data_bus_out;
    {rd_b, wr_b, cs_b} = 3'h7;
  endtask
endmodule

//--- verification/hpbp_port_tb_top.sv
// self-checking testbench of the host parallel bus port
`timescale 1ns/100ps
module hpbp_port_tb_top;
  logic        ref_clk, rst_b, aux_irq_in, rd_b, wr_b, cs_b, ale, irq_b;
  logic        oe_b, reg_rd_pulse, reg_wr_pulse, transmit_load, mux_mode;
  logic [7:0]  din, dout, mask, rx, thr, irq_src, reg_wdata, q, d, gw;
  logic [3:0]  addr_in, reg_addr, a, ga;
  logic        gl;
  int          n_rd = 0;
  int          r0 = 0;
  logic [31:0] seed = 32'hE484;
  int          fail_count = 0;
  int          n_compared = 0;

  // register file stand-in: data derived from the address
  wire [7:0] reg_rdata = {reg_addr, ~reg_addr};

  hpbp_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe_b(oe_b), .reg_addr_in(addr_in),
    .rd_b(rd_b), .wr_b(wr_b), .cs_b(cs_b), .ale(ale), .aux_irq_in(aux_irq_in),
    .irq_b(irq_b), .reg_addr(reg_addr), .reg_rd_pulse(reg_rd_pulse),
    .reg_wr_pulse(reg_wr_pulse), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_impl_mask(mask), .receive_holding_reg(rx), .transmit_holding_reg(thr),
    .transmit_load(transmit_load), .irq_src(irq_src), .mux_mode(mux_mode));

  hpbp_host_model m (.ref_clk(ref_clk), .host_data_bus_out(dout),
    .host_data_bus_oe_b(oe_b), .host_data_bus_in(din), .reg_addr_in(addr_in),
    .rd_b(rd_b), .wr_b(wr_b), .cs_b(cs_b), .ale(ale));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // read starts counted as the design announces them
  always @(negedge ref_clk) begin
    if (reg_rd_pulse === 1'b1) begin
      n_rd++;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // shared address returns receive data unmasked, others masked
  function automatic logic [7:0] exp_rd(input logic [3:0] x);
    return (x == hpbp_pkg::ADDR_RX_TX) ? rx : ({x, ~x} & mask);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write commit seen within a bounded span after release
  task automatic wait_wr();
    ga = 4'hX;
    gw = 8'hXX;
    gl = 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      if (reg_wr_pulse === 1'b1) begin
        ga = reg_addr;
        gw = reg_wdata;
        gl = transmit_load;
      end
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    {rst_b, aux_irq_in, irq_src, mask, rx} = {1'b0, 1'b0, 8'h00, 8'hFF, 8'h3C};
    repeat (2) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    @(negedge ref_clk);
    chk(mux_mode, 8'h00);
    chk(oe_b, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      #2 a = (i < 2) ? hpbp_pkg::ADDR_RX_TX : 4'(rnd());
      r0 = n_rd;
      d = 8'(rnd());
      mask = (i == 3) ? 8'h0F : 8'(rnd());
      rx = 8'(rnd());
      m.nm_acc(1'b0, a, d, q);
      wait_wr();
      chk({4'h0, ga}, {4'h0, a});
      chk(gw, d & mask);
      if (a == hpbp_pkg::ADDR_RX_TX)
        chk(thr, d & mask);
      chk({7'h0, gl}, {7'h0, a == hpbp_pkg::ADDR_RX_TX});
      m.nm_acc(1'b1, a, ~d, q);
      chk(q, exp_rd(a));
      chk(8'(n_rd - r0), 8'h01);
      m.idle(4);
      chk(oe_b, 8'h01);
    end
    $display("non-multiplexed test done");
    @(posedge ref_clk);
    #2 irq_src = 8'h10;
    repeat (3) @(negedge ref_clk);
    chk(irq_b, 8'h00);
    @(posedge ref_clk);
    #2 {irq_src, aux_irq_in} = {8'h00, 1'b1};
    repeat (3) @(negedge ref_clk);
    chk(irq_b, 8'h00);
    @(posedge ref_clk);
    #2 aux_irq_in = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(irq_b, 8'h01);
    $display("interrupt test done");
    m.mx_addr(4'h7, 1'b1);
    chk(mux_mode, 8'h01);
    r0 = n_rd;
    m.mx_acc(1'b1, 8'h00, q);
    chk(q, exp_rd(4'h7));
    chk(8'(n_rd - r0), 8'h01);
    chk({4'h0, reg_addr}, 8'h07);
    m.idle(5);
    chk(mux_mode, 8'h00);
    m.mx_addr(hpbp_pkg::ADDR_RX_TX, 1'b0);
    m.mx_acc(1'b0, 8'h96, q);
    wait_wr();
    chk(thr, 8'h96 & mask);
    chk(gw, 8'h96 & mask);
    chk({4'h0, ga}, {4'h0, hpbp_pkg::ADDR_RX_TX});
    chk({7'h0, gl}, 8'h01);
    $display("multiplexed test done");
    final_report();
  end
endmodule

//--- verilog/hpbp_pkg.sv
// shared constants and types of the host parallel bus port
package hpbp_pkg;

  // ----------------------------------------------------------------
  // register locations seen through the port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_RX_TX     = 4'hD;  // read = receive, write = transmit
  localparam logic [3:0] ADDR_RESET     = 4'h0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DATA_RESET     = 8'h00;
  // all high: strobes idle, and ale as if tied to supply, so that a pin
  // strapped high shows no false rising edge after reset
  localparam logic [3:0] STROBE_IDLE    = 4'hF;
  localparam logic       IRQ_B_RESET    = 1'b1;
  localparam logic       OE_B_RESET     = 1'b1;

  // ----------------------------------------------------------------
  // bit positions inside the synchronised strobe vector
  // ----------------------------------------------------------------
  localparam int unsigned STB_RD_B      = 0;
  localparam int unsigned STB_WR_B      = 1;
  localparam int unsigned STB_CS_B      = 2;
  localparam int unsigned STB_ALE       = 3;

  // bus mode, one-hot
  typedef enum logic [1:0] {
    HPBP_MODE_DEMUX = 2'b01,
    HPBP_MODE_MUX   = 2'b10
  } hpbp_mode_t;

endpackage

//--- verilog/hpbp_port.sv
// host parallel bus port: bus mode detection, address capture, strobes, interrupt pin
`timescale 1ns/100ps
module hpbp_port (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // host pins
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe_b,
  input  wire logic [3:0] reg_addr_in,
  input  wire logic       rd_b,
  input  wire logic       wr_b,
  input  wire logic       cs_b,
  input  wire logic       ale,
  input  wire logic       aux_irq_in,
  output logic            irq_b,
  // register file side
  output logic      [3:0] reg_addr,
  output logic            reg_rd_pulse,
  output logic            reg_wr_pulse,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic [7:0] reg_impl_mask,
  input  wire logic [7:0] receive_holding_reg,
  output logic      [7:0] transmit_holding_reg,
  output logic            transmit_load,
  input  wire logic [7:0] irq_src,
  output logic            mux_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]          stb1;      // first synchroniser stage
    logic [3:0]          stb2;      // second synchroniser stage
    logic [3:0]          stb3;      // previous value for edge detection
    logic [7:0]          data1;
    logic [7:0]          data2;     // bus data aligned with stb2
    logic [3:0]          addr1;
    logic [3:0]          addr2;     // address pins aligned with stb2
    hpbp_pkg::hpbp_mode_t mode;
    logic [3:0]          mux_addr;
    logic                rd_act;
    logic                wr_act;
    logic [3:0]          reg_addr;
    logic [7:0]          wdata;
    logic                rd_pulse;
    logic                wr_pulse;
    logic [7:0]          dout;
    logic                doe_b;
    logic [7:0]          thr;
    logic                thr_load;
    logic                irq_b;
  } hpbp_state_t;

  hpbp_state_t s_q;
  hpbp_state_t s_d;

  // access decode, shared by read and write paths
  function automatic logic [1:0] hpbp_decode(input logic       mux,
                                             input logic [3:0] stb);
    logic rd_n;
    logic wr_n;
    logic cs_n;
    rd_n = stb[hpbp_pkg::STB_RD_B];
    wr_n = stb[hpbp_pkg::STB_WR_B];
    cs_n = stb[hpbp_pkg::STB_CS_B];
    if (mux) begin
      hpbp_decode = {~cs_n & ~wr_n, ~cs_n & ~rd_n};
    end else begin
      hpbp_decode = {~cs_n & ~wr_n & ~rd_n, ~cs_n & ~wr_n & rd_n};
    end
  endfunction

  logic       ale_rise;
  logic       ale_fall;
  logic       cs_rise;
  logic       is_mux;
  logic [1:0] acc;
  logic [3:0] cur_addr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.stb1  = {ale, cs_b, wr_b, rd_b};
    s_d.stb2  = s_q.stb1;
    s_d.stb3  = s_q.stb2;
    s_d.data1 = host_data_bus_in;
    s_d.data2 = s_q.data1;
    s_d.addr1 = reg_addr_in;
    s_d.addr2 = s_q.addr1;

    ale_rise = s_q.stb2[hpbp_pkg::STB_ALE] & ~s_q.stb3[hpbp_pkg::STB_ALE];
    ale_fall = ~s_q.stb2[hpbp_pkg::STB_ALE] & s_q.stb3[hpbp_pkg::STB_ALE];
    cs_rise  = s_q.stb2[hpbp_pkg::STB_CS_B] & ~s_q.stb3[hpbp_pkg::STB_CS_B];
    is_mux   = (s_q.mode == hpbp_pkg::HPBP_MODE_MUX);

    // strobe edge enters multiplexed mode; it wins over a deselect
    if (ale_rise) begin
      s_d.mode = hpbp_pkg::HPBP_MODE_MUX;
    end else if (cs_rise) begin
      s_d.mode = hpbp_pkg::HPBP_MODE_DEMUX;
    end

    // capture low nibble at the falling strobe; select ignored
    if (is_mux && ale_fall) begin
      s_d.mux_addr = s_q.data2[3:0];
    end

    cur_addr = is_mux ? s_q.mux_addr : s_q.addr2;

    acc        = hpbp_decode(is_mux, s_q.stb2);
    s_d.rd_act = acc[0];
    s_d.wr_act = acc[1];
    if (acc[0] | acc[1]) begin
      s_d.reg_addr = cur_addr;
    end

    if (acc[1]) begin
      s_d.wdata = s_q.data2 & reg_impl_mask;
    end

    // reads are announced at the start, writes commit when the strobe ends
    // so that data still settling at strobe start is not taken
    s_d.rd_pulse = acc[0] & ~s_q.rd_act;
    s_d.wr_pulse = s_q.wr_act & ~acc[1];

    // shared address: writes go to the transmit holding register
    s_d.thr_load = s_d.wr_pulse && (s_q.reg_addr == hpbp_pkg::ADDR_RX_TX);
    if (s_d.thr_load) begin
      s_d.thr = s_q.wdata;
    end

    // shared address reads receive data; others masked
    if (s_q.rd_act) begin
      if (s_q.reg_addr == hpbp_pkg::ADDR_RX_TX) begin
        s_d.dout = receive_holding_reg;
      end else begin
        s_d.dout = reg_rdata & reg_impl_mask;
      end
    end

    // drive only during a selected read
    s_d.doe_b = ~(s_q.rd_act & acc[0]);

    s_d.irq_b = ~((|irq_src) | aux_irq_in);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset lands in non-multiplexed mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.stb1     <= hpbp_pkg::STROBE_IDLE;
      s_q.stb2     <= hpbp_pkg::STROBE_IDLE;
      s_q.stb3     <= hpbp_pkg::STROBE_IDLE;
      s_q.mode     <= hpbp_pkg::HPBP_MODE_DEMUX;
      s_q.mux_addr <= hpbp_pkg::ADDR_RESET;
      s_q.reg_addr <= hpbp_pkg::ADDR_RESET;
      s_q.dout     <= hpbp_pkg::DATA_RESET;
      s_q.thr      <= hpbp_pkg::DATA_RESET;
      s_q.doe_b    <= hpbp_pkg::OE_B_RESET;
      s_q.irq_b    <= hpbp_pkg::IRQ_B_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign host_data_bus_out    = s_q.dout;
  assign host_data_bus_oe_b   = s_q.doe_b;
  assign irq_b                = s_q.irq_b;
  assign reg_addr             = s_q.reg_addr;
  assign reg_rd_pulse         = s_q.rd_pulse;
  assign reg_wr_pulse         = s_q.wr_pulse;
  assign reg_wdata            = s_q.wdata;
  assign transmit_holding_reg = s_q.thr;
  assign transmit_load        = s_q.thr_load;
  assign mux_mode             = s_q.mode[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ale_rise;
    s_q.stb2[hpbp_pkg::STB_ALE] && !s_q.stb3[hpbp_pkg::STB_ALE];
  endsequence

  sequence s_cs_rise;
    s_q.stb2[hpbp_pkg::STB_CS_B] && !s_q.stb3[hpbp_pkg::STB_CS_B];
  endsequence

  sequence s_write_done;
    s_q.wr_act ##1 !s_q.wr_act;
  endsequence

  property p_stay_demux;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_q.mode == hpbp_pkg::HPBP_MODE_DEMUX) && !s_q.stb2[hpbp_pkg::STB_ALE]
      |=> (s_q.mode == hpbp_pkg::HPBP_MODE_DEMUX);
  endproperty
  a_stay_demux: assert property (p_stay_demux) else $error("left demux without strobe");

  property p_enter_mux;
    @(posedge ref_clk) disable iff (!rst_b)
    s_ale_rise |=> (s_q.mode == hpbp_pkg::HPBP_MODE_MUX);
  endproperty
  a_enter_mux: assert property (p_enter_mux) else $error("strobe edge did not enter mux");

  property p_leave_mux;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_q.mode == hpbp_pkg::HPBP_MODE_MUX) && !s_q.stb2[hpbp_pkg::STB_ALE] ##0 s_cs_rise
      |=> (s_q.mode == hpbp_pkg::HPBP_MODE_DEMUX);
  endproperty
  a_leave_mux: assert property (p_leave_mux) else $error("deselect kept mux mode");

  property p_mux_addr;
    @(posedge ref_clk) disable iff (!rst_b)
    mux_mode && !s_q.stb2[hpbp_pkg::STB_ALE] && s_q.stb3[hpbp_pkg::STB_ALE]
      |=> (s_q.mux_addr == $past(s_q.data2[3:0]));
  endproperty
  a_mux_addr: assert property (p_mux_addr) else $error("mux address not captured");

  property p_demux_addr;
    @(posedge ref_clk) disable iff (!rst_b)
    !mux_mode && !s_q.stb2[hpbp_pkg::STB_CS_B] && !s_q.stb2[hpbp_pkg::STB_WR_B]
      |=> (reg_addr == $past(s_q.addr2));
  endproperty
  a_demux_addr: assert property (p_demux_addr) else $error("demux address not used");

  property p_demux_dir;
    @(posedge ref_clk) disable iff (!rst_b)
    !mux_mode && !s_q.stb2[hpbp_pkg::STB_CS_B] && !s_q.stb2[hpbp_pkg::STB_WR_B]
      |=> (s_q.rd_act == $past(s_q.stb2[hpbp_pkg::STB_RD_B])) && (s_q.wr_act != s_q.rd_act);
  endproperty
  a_demux_dir: assert property (p_demux_dir) else $error("direction select wrong");

  property p_no_access_idle;
    @(posedge ref_clk) disable iff (!rst_b)
    s_q.stb2[hpbp_pkg::STB_CS_B] |=> !s_q.rd_act && !s_q.wr_act ##1 host_data_bus_oe_b;
  endproperty
  a_no_access_idle: assert property (p_no_access_idle) else $error("access while deselected");

  property p_write_commit;
    @(posedge ref_clk) disable iff (!rst_b)
    s_write_done |-> reg_wr_pulse ##1 !reg_wr_pulse;
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("write not committed once");

  property p_rx_read;
    @(posedge ref_clk) disable iff (!rst_b)
    s_q.rd_act && (reg_addr == hpbp_pkg::ADDR_RX_TX) |=> (host_data_bus_out == $past(receive_holding_reg));
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("shared address read wrong");

  property p_mask_read;
    @(posedge ref_clk) disable iff (!rst_b)
    s_q.rd_act && (reg_addr != hpbp_pkg::ADDR_RX_TX) |=> ((host_data_bus_out & ~$past(reg_impl_mask)) == 8'h00);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("unimplemented bits read nonzero");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_b)
    ((|irq_src) || aux_irq_in) |=> !irq_b;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin not low");

  property p_oe_read;
    @(posedge ref_clk) disable iff (!rst_b)
    !host_data_bus_oe_b |-> s_q.rd_act && $past(s_q.rd_act);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");

endmodule
